// ---- logic/ssc_pkg.sv ----
// Shared constants and types for the switching-frequency control block
package ssc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] SSC_OFS_LINE_CTRL = 8'h00;
  localparam logic [7:0] SSC_OFS_PAIR_CTRL = 8'h01;
  localparam logic [7:0] SSC_OFS_FREQ_SEL = 8'h02;
  localparam logic [7:0] SSC_OFS_STATE_CTRL = 8'h04;
  localparam logic [7:0] SSC_OFS_STATUS = 8'h05;
  localparam logic [7:0] SSC_OFS_FAULT_CTRL = 8'h21;
  localparam logic [7:0] SSC_OFS_PHASE_SETUP = 8'h28;
  localparam logic [7:0] SSC_OFS_SPREAD_EN_AMP = 8'h77;
  localparam logic [7:0] SSC_OFS_SPREAD_CENTER = 8'h78;
  localparam logic [7:0] SSC_OFS_SPREAD_STEP = 8'h79;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] SSC_RST_ZERO = 8'h00;
  localparam logic [7:0] SSC_RST_PHASE_SETUP = 8'h0A;
  localparam logic [7:0] SSC_RST_SPREAD_CENTER = 8'h3F;
  localparam logic [7:0] SSC_RST_STATE_CTRL = 8'h55;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SSC_BIT_BW_SEL = 7;
  localparam int SSC_BIT_POST_DIV = 6;
  localparam int SSC_BIT_PHASE_SEL = 5;
  localparam int SSC_BIT_SPREAD_EN = 7;
  localparam int SSC_BIT_CLEAR_FAULT = 7;
  localparam int SSC_FIELD_W = 7;
  localparam int SSC_NUM_CH = 4;
  localparam int SSC_NUM_PAIR = 2;
  // ----------------------------------------
  // Channel operating states, two bits per channel
  // ----------------------------------------
  typedef enum logic [1:0] {
    SSC_ST_PLAY = 2'b00,
    SSC_ST_STANDBY = 2'b01,
    SSC_ST_MUTE = 2'b10,
    SSC_ST_DIAG = 2'b11
  } ssc_state_t;
  // ----------------------------------------
  // Switching-frequency choices and multiples of the sample rate
  // ----------------------------------------
  localparam logic [2:0] SSC_FSEL_8 = 3'h0;
  localparam logic [2:0] SSC_FSEL_10 = 3'h1;
  localparam logic [2:0] SSC_FSEL_38 = 3'h2;
  localparam logic [2:0] SSC_FSEL_44 = 3'h3;
  localparam logic [2:0] SSC_FSEL_48 = 3'h4;
  localparam logic [5:0] SSC_MULT_8 = 6'h08;
  localparam logic [5:0] SSC_MULT_10 = 6'h0A;
  localparam logic [5:0] SSC_MULT_38 = 6'h26;
  localparam logic [5:0] SSC_MULT_44 = 6'h2C;
  localparam logic [5:0] SSC_MULT_48 = 6'h30;
  localparam logic [8:0] SSC_CENTER_NUM = 9'h100;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SSC_CLK_HZ = 20000000;
  localparam int SSC_UPDATE_NS = 5000;
  localparam int SSC_UPDATE_CYCLES = (SSC_UPDATE_NS * (SSC_CLK_HZ / 1000000)) / 1000;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssc_bus_req_t;
  typedef struct packed {
    logic [5:0] sw_mult;
    logic [7:0] center_div;
    logic signed [9:0] freq_offset;
    logic spread_active;
  } ssc_sw_cfg_t;
endpackage

// ---- logic/ssc_ctrl.sv ----
// Switching-frequency, spread-spectrum and bridge-pairing control block
// ----------------------------------------
// ----------------------------------------
module ssc_ctrl #(
  parameter int UPDATE_CYCLES = ssc_pkg::SSC_UPDATE_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire ssc_pkg::ssc_bus_req_t bus_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output ssc_pkg::ssc_sw_cfg_t sw_cfg,
  output logic [3:0] line_mode,
  output logic [1:0] parallel_bridge_mode,
  output logic [3:0] diag_chan,
  output logic pair_fault,
  output logic phase_ok
);
  import ssc_pkg::*;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] line_ctrl;
  logic [1:0] pair_req;
  logic [2:0] freq_sel;
  logic [7:0] state_ctrl;
  logic [7:0] fault_ctrl;
  logic [7:0] phase_and_spread_setup;
  logic [7:0] spread_enable_amplitude;
  logic [7:0] spread_center_divider;
  logic [7:0] spread_step_size;
  logic signed [9:0] offset;
  logic sweep_up;
  logic [15:0] tick_cnt;

  // Write strobes per offset
  function automatic logic hit(input ssc_bus_req_t r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic [6:0] spread_amplitude = spread_enable_amplitude[SSC_FIELD_W-1:0];
  wire logic [6:0] pre_div = spread_center_divider[SSC_FIELD_W-1:0];
  wire logic spread_bandwidth_select = phase_and_spread_setup[SSC_BIT_BW_SEL];
  wire logic spread_post_divider = phase_and_spread_setup[SSC_BIT_POST_DIV];
  wire logic spread_en = spread_enable_amplitude[SSC_BIT_SPREAD_EN];
  // Spread needs enable plus both qualifiers
  // qualifier gating
  wire logic spread_active = spread_en && spread_bandwidth_select && spread_post_divider;
  // Center divisor 2*pre_div + 2, wrapping to zero at pre_div 127
  // center divisor
  wire logic [7:0] center_div = {pre_div, 1'b0} + 8'h02;
  wire logic signed [9:0] amp_s = signed'({3'h0, spread_amplitude});
  wire logic signed [9:0] step_s = signed'({2'h0, spread_step_size});
  wire logic signed [9:0] up_val = offset + step_s;
  wire logic signed [9:0] dn_val = offset - step_s;
  // Offset shown only while active, so a dropped qualifier never leaves a stale offset
  wire logic signed [9:0] shown_offset = spread_active ? offset : 10'sd0;
  wire logic tick = (tick_cnt == 16'(UPDATE_CYCLES - 1));
  wire logic in_standby = (state_ctrl == SSC_RST_STATE_CTRL);
  // Paired channels must agree in state
  wire logic [1:0] pair_mismatch;
  wire logic clear_fault = fault_ctrl[SSC_BIT_CLEAR_FAULT];

  genvar gp;
  generate
    for (gp = 0; gp < SSC_NUM_PAIR; gp++) begin : g_pair
      assign pair_mismatch[gp] = parallel_bridge_mode[gp] &&
        (state_ctrl[4*gp+1:4*gp] != state_ctrl[4*gp+3:4*gp+2]);
    end
  endgenerate

  // diagnostics reach both halves of a pair
  genvar gc;
  generate
    for (gc = 0; gc < SSC_NUM_CH; gc++) begin : g_diag
      assign diag_chan[gc] = (state_ctrl[2*gc+1:2*gc] == SSC_ST_DIAG) ||
        (parallel_bridge_mode[gc/2] && (state_ctrl[2*(gc^1)+1:2*(gc^1)] == SSC_ST_DIAG));
    end
  endgenerate

  // Switching multiple selection; unknown codes fall back to 44
  // frequency multiples
  logic [5:0] next_mult;
  always_comb begin
    case (freq_sel)
      SSC_FSEL_8: next_mult = SSC_MULT_8;
      SSC_FSEL_10: next_mult = SSC_MULT_10;
      SSC_FSEL_38: next_mult = SSC_MULT_38;
      SSC_FSEL_48: next_mult = SSC_MULT_48;
      default: next_mult = SSC_MULT_44;
    endcase
  end

  // Read multiplexer; unmapped offsets read zero
  logic [7:0] next_rd;
  always_comb begin
    case (bus_req.addr)
      SSC_OFS_LINE_CTRL: next_rd = line_ctrl;
      SSC_OFS_PAIR_CTRL: next_rd = {6'h00, pair_req};
      SSC_OFS_FREQ_SEL: next_rd = {5'h00, freq_sel};
      SSC_OFS_STATE_CTRL: next_rd = state_ctrl;
      SSC_OFS_STATUS: next_rd = {4'h0, spread_active, pair_fault, parallel_bridge_mode};
      SSC_OFS_FAULT_CTRL: next_rd = fault_ctrl;
      SSC_OFS_PHASE_SETUP: next_rd = phase_and_spread_setup;
      SSC_OFS_SPREAD_EN_AMP: next_rd = spread_enable_amplitude;
      SSC_OFS_SPREAD_CENTER: next_rd = spread_center_divider;
      SSC_OFS_SPREAD_STEP: next_rd = spread_step_size;
      default: next_rd = SSC_RST_ZERO;
    endcase
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // configuration storage
  always_ff @(posedge mclk) begin
    if (srst) begin
      line_ctrl <= SSC_RST_ZERO;
      pair_req <= 2'h0;
      freq_sel <= SSC_FSEL_44;
      state_ctrl <= SSC_RST_STATE_CTRL;
      fault_ctrl <= SSC_RST_ZERO;
      phase_and_spread_setup <= SSC_RST_PHASE_SETUP;
      spread_enable_amplitude <= SSC_RST_ZERO;
      spread_center_divider <= SSC_RST_SPREAD_CENTER;
      spread_step_size <= SSC_RST_ZERO;
    end else begin
      if (hit(bus_req, SSC_OFS_LINE_CTRL)) line_ctrl <= bus_req.wdata;
      if (hit(bus_req, SSC_OFS_PAIR_CTRL)) pair_req <= bus_req.wdata[1:0];
      if (hit(bus_req, SSC_OFS_FREQ_SEL)) freq_sel <= bus_req.wdata[2:0];
      if (hit(bus_req, SSC_OFS_STATE_CTRL)) state_ctrl <= bus_req.wdata;
      if (hit(bus_req, SSC_OFS_FAULT_CTRL)) fault_ctrl <= bus_req.wdata;
      if (hit(bus_req, SSC_OFS_PHASE_SETUP)) phase_and_spread_setup <= bus_req.wdata;
      if (hit(bus_req, SSC_OFS_SPREAD_EN_AMP)) spread_enable_amplitude <= bus_req.wdata;
      if (hit(bus_req, SSC_OFS_SPREAD_CENTER)) spread_center_divider <= bus_req.wdata;
      if (hit(bus_req, SSC_OFS_SPREAD_STEP)) spread_step_size <= bus_req.wdata;
    end
  end

  // Pairing is copied only in standby so live channels never re-wire
  // standby-only pairing
  always_ff @(posedge mclk) begin
    if (srst) parallel_bridge_mode <= 2'h0;
    else if (in_standby) parallel_bridge_mode <= pair_req;
  end

  // Sticky pair fault; a new mismatch beats the clear
  // sticky fault
  always_ff @(posedge mclk) begin
    if (srst) pair_fault <= 1'b0;
    else if (|pair_mismatch) pair_fault <= 1'b1;
    else if (clear_fault) pair_fault <= 1'b0;
  end

  // Update timer for the sweep
  always_ff @(posedge mclk) begin
    if (srst || tick) tick_cnt <= 16'h0000;
    else tick_cnt <= tick_cnt + 16'h0001;
  end

  // Triangle sweep, clamped at the amplitude bounds
  // triangle sweep
  always_ff @(posedge mclk) begin
    if (srst || !spread_active) begin
      offset <= 10'sd0;
      sweep_up <= 1'b1;
    end else if (tick) begin
      if (sweep_up) begin
        if (up_val >= amp_s) begin
          offset <= amp_s;
          sweep_up <= 1'b0;
        end else offset <= up_val;
      end else begin
        if (dn_val <= -amp_s) begin
          offset <= -amp_s;
          sweep_up <= 1'b1;
        end else offset <= dn_val;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      sw_cfg <= '0;
      rd_data <= SSC_RST_ZERO;
      rd_valid <= 1'b0;
      line_mode <= 4'h0;
      phase_ok <= 1'b0;
    end else begin
      sw_cfg <= '{sw_mult: next_mult, center_div: center_div, freq_offset: shown_offset, spread_active: spread_active};
      rd_data <= bus_req.rd ? next_rd : rd_data;
      rd_valid <= bus_req.rd;
      line_mode <= line_ctrl[SSC_NUM_CH-1:0];
      phase_ok <= phase_and_spread_setup[SSC_BIT_PHASE_SEL];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_SPREAD_QUAL: assert property (@(posedge mclk) disable iff (srst)
    (!spread_bandwidth_select || !spread_post_divider) |=> !sw_cfg.spread_active && sw_cfg.freq_offset == 10'sd0)
    else $error("spread active without qualifiers");
  AST_POST_DIV: assert property (@(posedge mclk) disable iff (srst)
    $fell(spread_post_divider) |=> !sw_cfg.spread_active)
    else $error("spread survived post-divider clear");
  AST_AMP_BOUND: assert property (@(posedge mclk) disable iff (srst)
    offset <= amp_s || !spread_active || $changed(spread_amplitude) || $past(offset) > amp_s)
    else $error("offset above amplitude");
  AST_CENTER: assert property (@(posedge mclk) disable iff (srst)
    !$past(srst) |-> sw_cfg.center_div == {$past(pre_div), 1'b0} + 8'h02)
    else $error("center divisor wrong");
  AST_STEP: assert property (@(posedge mclk) disable iff (srst)
    spread_active && tick && sweep_up && up_val < amp_s && $stable(spread_active) |=> offset == $past(up_val))
    else $error("sweep step wrong");
  AST_MULT: assert property (@(posedge mclk) disable iff (srst)
    freq_sel == SSC_FSEL_38 ##1 freq_sel == SSC_FSEL_38 |-> sw_cfg.sw_mult == SSC_MULT_38)
    else $error("multiple 38 wrong");
  AST_MULT_LOW: assert property (@(posedge mclk) disable iff (srst)
    freq_sel == SSC_FSEL_10 ##1 freq_sel == SSC_FSEL_10 |-> sw_cfg.sw_mult == SSC_MULT_10)
    else $error("multiple 10 wrong");
  AST_FAULT: assert property (@(posedge mclk) disable iff (srst)
    |pair_mismatch |=> pair_fault)
    else $error("pair mismatch not reported");
  AST_STANDBY: assert property (@(posedge mclk) disable iff (srst)
    !$past(in_standby) |-> $stable(parallel_bridge_mode))
    else $error("pairing changed outside standby");
  AST_DIAG: assert property (@(posedge mclk) disable iff (srst)
    parallel_bridge_mode[0] && state_ctrl[1:0] == SSC_ST_DIAG |-> diag_chan[1:0] == 2'b11)
    else $error("paired diagnostics incomplete");
  AST_LINE: assert property (@(posedge mclk) disable iff (srst)
    ##1 line_mode == $past(line_ctrl[3:0]))
    else $error("line mode not applied");
  AST_PHASE: assert property (@(posedge mclk) disable iff (srst)
    ##1 phase_ok == $past(phase_and_spread_setup[SSC_BIT_PHASE_SEL]))
    else $error("phase select not applied");
  // Qualifiers switch the sweep on as well as off
  AST_SPREAD_ON: assert property (@(posedge mclk) disable iff (srst)
    spread_en && spread_bandwidth_select && spread_post_divider |=> sw_cfg.spread_active)
    else $error("spread not active with all qualifiers");
  // Lower bound and downward steps of the triangle
  AST_AMP_FLOOR: assert property (@(posedge mclk) disable iff (srst)
    spread_active && $stable(spread_active) && $stable(spread_amplitude) &&
    $past(offset) >= -amp_s |-> offset >= -amp_s)
    else $error("offset below amplitude");
  AST_STEP_DOWN: assert property (@(posedge mclk) disable iff (srst)
    spread_active && tick && !sweep_up && dn_val > -amp_s && $stable(spread_active) |=> offset == $past(dn_val))
    else $error("sweep down step wrong");
  // Step register reads back as stored
  AST_STEP_READ: assert property (@(posedge mclk) disable iff (srst)
    bus_req.rd && bus_req.addr == SSC_OFS_SPREAD_STEP |=> rd_valid && rd_data == $past(spread_step_size))
    else $error("step register read wrong");
  // Switching multiples 48 and 8
  AST_MULT_HIGH: assert property (@(posedge mclk) disable iff (srst)
    freq_sel == SSC_FSEL_48 ##1 freq_sel == SSC_FSEL_48 |-> sw_cfg.sw_mult == SSC_MULT_48)
    else $error("multiple 48 wrong");
  AST_MULT_LOW8: assert property (@(posedge mclk) disable iff (srst)
    freq_sel == SSC_FSEL_8 ##1 freq_sel == SSC_FSEL_8 |-> sw_cfg.sw_mult == SSC_MULT_8)
    else $error("multiple 8 wrong");
  // Fault flag holds until cleared with no mismatch
  AST_FAULT_HOLD: assert property (@(posedge mclk) disable iff (srst)
    pair_fault && !clear_fault |=> pair_fault)
    else $error("pair fault dropped without clear");
  AST_FAULT_CLEAR: assert property (@(posedge mclk) disable iff (srst)
    clear_fault && !(|pair_mismatch) |=> !pair_fault)
    else $error("pair fault survived clear");
  // Pairing request lands in standby
  AST_PAIR_APPLY: assert property (@(posedge mclk) disable iff (srst)
    in_standby |=> parallel_bridge_mode == $past(pair_req))
    else $error("pairing not applied in standby");
  AST_DIAG_PAIR2: assert property (@(posedge mclk) disable iff (srst)
    parallel_bridge_mode[1] && state_ctrl[5:4] == SSC_ST_DIAG |-> diag_chan[3:2] == 2'b11)
    else $error("second pair diagnostics incomplete");
  COV_SWEEP_TURN: cover property (@(posedge mclk) disable iff (srst) spread_active && tick && sweep_up ##1 !sweep_up);
  COV_PAIR_FAULT: cover property (@(posedge mclk) disable iff (srst) $rose(pair_fault));
  COV_PAIR_APPLY: cover property (@(posedge mclk) disable iff (srst) $rose(parallel_bridge_mode[1]));
  COV_SPREAD_DROP: cover property (@(posedge mclk) disable iff (srst) $fell(sw_cfg.spread_active));
  COV_FAULT_CLEARED: cover property (@(posedge mclk) disable iff (srst) $fell(pair_fault));
endmodule // ssc_ctrl

// ---- bench/ssc_ctrl_test.sv ----
// Self-checking testbench for the switching-frequency control block
module ssc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ssc_pkg::*;
  // ----------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------
  localparam int UPD = 4;
  localparam logic [2:0] FSELS [5] = '{SSC_FSEL_8, SSC_FSEL_10, SSC_FSEL_38, SSC_FSEL_44, SSC_FSEL_48};
  localparam logic [5:0] MULTS [5] = '{SSC_MULT_8, SSC_MULT_10, SSC_MULT_38, SSC_MULT_44, SSC_MULT_48};
  logic mclk;
  logic srst;
  ssc_bus_req_t bus_req;
  logic [7:0] rd_data;
  logic rd_valid;
  ssc_sw_cfg_t sw_cfg;
  logic [3:0] line_mode;
  logic [1:0] parallel_bridge_mode;
  logic [3:0] diag_chan;
  logic pair_fault;
  logic phase_ok;
  int fails;
  int tests_run;
  logic [7:0] exp_q[$];

  // Short sweep period keeps the triangle test brief
  ssc_ctrl #(.UPDATE_CYCLES(UPD)) DUT (
    .mclk(mclk),
    .srst(srst),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .sw_cfg(sw_cfg),
    .line_mode(line_mode),
    .parallel_bridge_mode(parallel_bridge_mode),
    .diag_chan(diag_chan),
    .pair_fault(pair_fault),
    .phase_ok(phase_ok)
  );

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run();
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle strobe, then settle; returns at a falling edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge mclk);
    bus_req <= '0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  // Expectation noted before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask

  // Read answers matched against the oldest note
  always @(negedge mclk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("[ERR] rd_data expected none seen %h", rd_data);
      end else begin
        chk("rd_data", {8'h00, exp_q.pop_front()}, {8'h00, rd_data});
      end
    end
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [3:0] lm;
    logic [6:0] pd;
    logic [7:0] st;
    int lo;
    int hi;
    int dmax;
    int prev;
    int cur;
    void'($urandom(37994));
    srst = 1'b1;
    bus_req = '0;
    fails = 0;
    tests_run = 0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    // Reset values and an unmapped offset
    rd(SSC_OFS_SPREAD_EN_AMP, SSC_RST_ZERO);
    rd(SSC_OFS_SPREAD_CENTER, SSC_RST_SPREAD_CENTER);
    rd(SSC_OFS_SPREAD_STEP, SSC_RST_ZERO);
    rd(SSC_OFS_PHASE_SETUP, SSC_RST_PHASE_SETUP);
    rd(8'h10, 8'h00);
    chk("center", {8'h00, {SSC_RST_SPREAD_CENTER[6:0], 1'b0} + 8'h02}, {8'h00, sw_cfg.center_div});
    // Every switching multiple in turn
    for (int i = 0; i < 5; i++) begin
      wr(SSC_OFS_FREQ_SEL, {5'h00, FSELS[i]});
      chk("sw_mult", {10'h000, MULTS[i]}, {10'h000, sw_cfg.sw_mult});
    end
    // Random line-driver channels and pre-divider
    lm = 4'($urandom_range(15, 1));
    wr(SSC_OFS_LINE_CTRL, {4'h0, lm});
    chk("line_mode", {12'h000, lm}, {12'h000, line_mode});
    pd = 7'($urandom_range(126, 0));
    wr(SSC_OFS_SPREAD_CENTER, {1'b0, pd});
    chk("center", {8'h00, {pd, 1'b0} + 8'h02}, {8'h00, sw_cfg.center_div});
    st = 8'($urandom_range(3, 1));
    wr(SSC_OFS_SPREAD_STEP, st);
    rd(SSC_OFS_SPREAD_STEP, st);
    // Spread stays off until both qualifiers are set
    wr(SSC_OFS_SPREAD_EN_AMP, 8'h85);
    wr(SSC_OFS_PHASE_SETUP, 8'hAA);
    chk("active", 16'h0000, {15'h0000, sw_cfg.spread_active});
    wr(SSC_OFS_PHASE_SETUP, 8'h6A);
    chk("active", 16'h0000, {15'h0000, sw_cfg.spread_active});
    chk("phase_ok", 16'h0001, {15'h0000, phase_ok});
    wr(SSC_OFS_PHASE_SETUP, 8'hEA);
    chk("active", 16'h0001, {15'h0000, sw_cfg.spread_active});
    // Triangle must touch both bounds, moving one step at a time
    lo = 0;
    hi = 0;
    dmax = 0;
    prev = int'(sw_cfg.freq_offset);
    repeat (150) begin
      @(negedge mclk);
      cur = int'(sw_cfg.freq_offset);
      lo = (cur < lo) ? cur : lo;
      hi = (cur > hi) ? cur : hi;
      dmax = ((cur - prev) > dmax) ? (cur - prev) : dmax;
      dmax = ((prev - cur) > dmax) ? (prev - cur) : dmax;
      prev = cur;
    end
    chk("offset_hi", 16'(5), 16'(hi));
    chk("offset_lo", 16'(-5), 16'(lo));
    chk("offset_step", {8'h00, st}, 16'(dmax));
    rd(SSC_OFS_STATUS, 8'h08);
    // Dropping the post divider stops the sweep at once
    wr(SSC_OFS_PHASE_SETUP, 8'hAA);
    chk("active", 16'h0000, {15'h0000, sw_cfg.spread_active});
    chk("offset_off", 16'h0000, 16'(sw_cfg.freq_offset));
    wr(SSC_OFS_PHASE_SETUP, 8'hEA);
    // Pairing taken in standby, frozen outside it
    wr(SSC_OFS_PAIR_CTRL, 8'h01);
    chk("pbm", 16'h0001, {14'h0000, parallel_bridge_mode});
    wr(SSC_OFS_STATE_CTRL, 8'h53);
    chk("diag_chan", 16'h0003, {12'h000, diag_chan});
    chk("pair_fault", 16'h0001, {15'h0000, pair_fault});
    wr(SSC_OFS_PAIR_CTRL, 8'h03);
    chk("pbm", 16'h0001, {14'h0000, parallel_bridge_mode});
    // Clear loses while the pair still disagrees
    wr(SSC_OFS_FAULT_CTRL, 8'h80);
    chk("pair_fault", 16'h0001, {15'h0000, pair_fault});
    wr(SSC_OFS_STATE_CTRL, 8'h50);
    chk("pair_fault", 16'h0000, {15'h0000, pair_fault});
    wr(SSC_OFS_FAULT_CTRL, 8'h00);
    // Unpaired channels may differ freely
    wr(SSC_OFS_STATE_CTRL, 8'h40);
    chk("pair_fault", 16'h0000, {15'h0000, pair_fault});
    wr(SSC_OFS_STATE_CTRL, SSC_RST_STATE_CTRL);
    wr(SSC_OFS_PAIR_CTRL, 8'h03);
    chk("pbm", 16'h0003, {14'h0000, parallel_bridge_mode});
    // Faults cleared and checked in standby before play
    wr(SSC_OFS_FAULT_CTRL, 8'h80);
    wr(SSC_OFS_FAULT_CTRL, 8'h00);
    rd(SSC_OFS_STATUS, 8'h0B);
    wr(SSC_OFS_STATE_CTRL, 8'h00);
    chk("pbm", 16'h0003, {14'h0000, parallel_bridge_mode});
    // Second pair both in diagnostics
    wr(SSC_OFS_STATE_CTRL, 8'hF0);
    chk("diag_chan", 16'h000C, {12'h000, diag_chan});
    chk("pair_fault", 16'h0000, {15'h0000, pair_fault});
    chk("pending", 16'h0000, 16'(exp_q.size()));
    complete_run();
  end
endmodule // ssc_ctrl_test
